// ===== hdl/dpot_map.vh
// Command codes, field positions and timing counts for the pot command unit
`ifndef DPOT_MAP_VH
`define DPOT_MAP_VH
// ************************************************************
// Address byte
// ************************************************************
// Device-type code of the address byte; value arbitrary, any fixed nibble
`define DPOT_TYPE_CODE 4'h6
`define DPOT_TYPE_MSB 7
`define DPOT_TYPE_LSB 4
// ************************************************************
// Instruction byte opcodes (upper nibble)
// ************************************************************
`define DPOT_OP_RD_WIPER 4'h9
`define DPOT_OP_WR_WIPER 4'ha
`define DPOT_OP_RD_SET 4'hb
`define DPOT_OP_WR_SET 4'hc
`define DPOT_OP_SET_TO_WIPER 4'hd
`define DPOT_OP_WIPER_TO_SET 4'he
`define DPOT_OP_GLB_TO_WIPER 4'h1
`define DPOT_OP_GLB_TO_SET 4'h8
`define DPOT_OP_STEP 4'h2
`define DPOT_OP_STATUS 4'h5
// ************************************************************
// Timing
// ************************************************************
`define DPOT_CLK_MHZ 25
`define DPOT_NV_WRITE_MS 5
`define DPOT_NV_WRITE_CYC (`DPOT_NV_WRITE_MS * 1000 * `DPOT_CLK_MHZ)
`define DPOT_WIPER_DELAY_US 10
`define DPOT_WIPER_DELAY_CYC (`DPOT_WIPER_DELAY_US * `DPOT_CLK_MHZ)
`endif

// ===== hdl/dpot_tap_decode.v
// One-hot tap decoder for a single wiper position
`timescale 1ns/10ps
module dpot_tap_decode (
    input wire [7:0] position_in, // Wiper position
    output wire [255:0] taps_out  // Exactly one tap closed
);
    // ************************************************************
    // Decode
    // ************************************************************
    // One output per tap, each a compare against its index
    genvar i;
    generate
        for (i = 0; i < 256; i = i + 1) begin : g_tap
            localparam [7:0] TAP_IDX = i;
            assign taps_out[i] = (position_in == TAP_IDX);
        end
    endgenerate
endmodule // dpot_tap_decode

// ===== hdl/dpot_cmd_unit.v
// Serial command interpreter and register set for a dual potentiometer
// Notes on behaviour
// - Two 8-bit wipers decoded to one-of-256 taps
// - Power-up loads wipers from slot zero
// - Four stored 8-bit settings per pot
// - Stored write completes within 5 ms
// - Save starts when select rises after sequence
// - Status returns write-pending flag, 1 busy
// - Read wiper returns selected wiper byte
// - Write wiper loads third byte
// - Read setting returns pot/slot selected register
// - Write setting stores byte, then save cycle
// - Copies are two bytes, run at select high
// - Copy selected slot into its wiper
// - Copy wiper into selected slot, save
// - Global copy slot into every wiper
// - Global copy every wiper into slot, save
// - Wiper-to-slot copy reports pending during save
// - Analog wiper follows within response delay
// - Step pulse with input high increments
// - Step pulse with input low decrements
// - Address byte type code, zeros, pin match
// - Stored writes start programming after termination
`timescale 1ns/10ps
`include "dpot_map.vh"
module dpot_cmd_unit #(
    parameter NV_WRITE_CYC = `DPOT_NV_WRITE_CYC,       // Save duration
    parameter WIPER_DELAY_CYC = `DPOT_WIPER_DELAY_CYC  // Wiper settle
) (
    input wire clk_in,                   // System clock 25 MHz
    input wire reset_n_in,               // Async reset, power-up
    input wire clk_en_in,                // Freezes state while low
    input wire sck_in,                   // Serial clock pin
    input wire cs_n_in,                  // Chip select pin, low active
    input wire si_in,                    // Serial data in pin
    input wire [1:0] board_address_pins_in, // Board address straps
    output reg so_out,                   // Serial data out
    output reg so_oe_out,                // Serial out enable
    output reg write_pending_flag_out,   // Save cycle in progress
    output reg [7:0] wiper0_out,         // Settled wiper 0 position
    output reg [7:0] wiper1_out,         // Settled wiper 1 position
    output reg [255:0] taps0_out,        // Tap switches pot 0
    output reg [255:0] taps1_out         // Tap switches pot 1
);
    // ************************************************************
    // States
    // ************************************************************
    localparam ST_LOAD = 6'b000001;
    localparam ST_ADDR = 6'b000010;
    localparam ST_INSTR = 6'b000100;
    localparam ST_DATA = 6'b001000;
    localparam ST_STEP = 6'b010000;
    localparam ST_IGNORE = 6'b100000;

    reg [5:0] state;
    reg [7:0] wiper_position_reg [0:1];
    reg [7:0] stored_setting_reg [0:7];
    reg [7:0] shift;
    reg [2:0] bit_cnt;
    reg [3:0] opcode_field;
    reg [1:0] slot_select_field;
    reg [1:0] pot_select_field;
    reg [7:0] data_byte;
    reg data_done;
    reg [7:0] tx;
    reg [2:0] load_idx;
    reg save_armed;
    reg [2:0] save_kind;
    reg [23:0] nv_cnt;
    reg [1:0] sck_sync;
    reg [1:0] cs_sync;
    reg [1:0] si_sync;
    reg [1:0] addr_sync;
    reg [1:0] addr_meta;
    reg sck_q;
    reg cs_q;
    reg [15:0] settle_cnt;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire cs_fall;
    wire [2:0] sel_idx;
    wire pot;
    wire [7:0] next_shift;
    wire [255:0] dec0;
    wire [255:0] dec1;

    localparam SAVE_SET = 3'b001;
    localparam SAVE_ONE = 3'b010;
    localparam SAVE_ALL = 3'b100;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two stages; only the second stage and later feed logic
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_sync <= 2'b00;
            cs_sync <= 2'b11;
            si_sync <= 2'b00;
            addr_meta <= 2'b00;
            addr_sync <= 2'b00;
            sck_q <= 1'b0;
            cs_q <= 1'b1;
        end else if (clk_en_in) begin
            sck_sync <= {sck_sync[0], sck_in};
            cs_sync <= {cs_sync[0], cs_n_in};
            si_sync <= {si_sync[0], si_in};
            addr_meta <= board_address_pins_in;
            addr_sync <= addr_meta;
            sck_q <= sck_sync[1];
            cs_q <= cs_sync[1];
        end
    end

    // Edge detection on synchronised pins
    assign sck_rise = sck_sync[1] & ~sck_q;
    assign sck_fall = ~sck_sync[1] & sck_q;
    assign cs_rise = cs_sync[1] & ~cs_q;
    assign cs_fall = ~cs_sync[1] & cs_q;
    assign next_shift = {shift[6:0], si_sync[1]};
    assign pot = pot_select_field[0];
    assign sel_idx = {pot, slot_select_field};

    // ************************************************************
    // Command sequencer and register set
    // ************************************************************
    // Register writes other than steps land at sequence end so a short frame is harmless
    integer k;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_LOAD;
            shift <= 8'h00;
            bit_cnt <= 3'h0;
            opcode_field <= 4'h0;
            slot_select_field <= 2'b00;
            pot_select_field <= 2'b00;
            data_byte <= 8'h00;
            data_done <= 1'b0;
            tx <= 8'h00;
            load_idx <= 3'h0;
            save_armed <= 1'b0;
            save_kind <= 3'b000;
            nv_cnt <= 24'h000000;
            write_pending_flag_out <= 1'b0;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            wiper_position_reg[0] <= 8'h00;
            wiper_position_reg[1] <= 8'h00;
            // Storage models non-volatile cells; cleared on every reset
            for (k = 0; k < 8; k = k + 1)
                stored_setting_reg[k] <= 8'h00;
        end else if (clk_en_in) begin
            // Save timer runs whatever the link does
            if (write_pending_flag_out) begin
                if (nv_cnt == NV_WRITE_CYC[23:0] - 24'h000001) begin
                    write_pending_flag_out <= 1'b0;
                    nv_cnt <= 24'h000000;
                end else begin
                    nv_cnt <= nv_cnt + 24'h000001;
                end
            end
            if (cs_fall) begin
                shift <= 8'h00;
                bit_cnt <= 3'h0;
                data_done <= 1'b0;
                save_armed <= 1'b0;
            end
            case (state)
                ST_LOAD: begin
                    // Walk both pots once; slot zero into each wiper
                    wiper_position_reg[load_idx[0]] <=
                        stored_setting_reg[{load_idx[0], 2'b00}];
                    load_idx <= load_idx + 3'h1;
                    if (load_idx[0])
                        state <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (!cs_sync[1] && sck_rise) begin
                        shift <= next_shift;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            if (next_shift[7:4] == `DPOT_TYPE_CODE &&
                                next_shift[3:2] == 2'b00 &&
                                next_shift[1:0] == addr_sync)
                                state <= ST_INSTR;
                            else
                                state <= ST_IGNORE;
                        end
                    end
                end
                ST_INSTR: begin
                    if (cs_rise) begin
                        state <= ST_ADDR;
                    end else if (sck_rise) begin
                        shift <= next_shift;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            opcode_field <= next_shift[7:4];
                            slot_select_field <= next_shift[3:2];
                            pot_select_field <= next_shift[1:0];
                            // Load reply byte for the read commands
                            case (next_shift[7:4])
                                `DPOT_OP_RD_WIPER:
                                    tx <= wiper_position_reg[next_shift[0]];
                                `DPOT_OP_RD_SET:
                                    tx <= stored_setting_reg[{next_shift[0],
                                        next_shift[3:2]}];
                                `DPOT_OP_STATUS:
                                    tx <= {7'h00,
                                        write_pending_flag_out};
                                default: tx <= 8'h00;
                            endcase
                            if (next_shift[7:4] == `DPOT_OP_STEP)
                                state <= ST_STEP;
                            else
                                state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (cs_rise) begin
                        state <= ST_ADDR;
                        // Actions run on deselect only
                        case (opcode_field)
                            `DPOT_OP_WR_WIPER:
                                if (data_done)
                                    wiper_position_reg[pot] <=
                                        data_byte;
                            `DPOT_OP_SET_TO_WIPER:
                                if (!data_done)
                                    wiper_position_reg[pot] <=
                                        stored_setting_reg[sel_idx];
                            `DPOT_OP_GLB_TO_WIPER:
                                if (!data_done) begin
                                    wiper_position_reg[0] <= stored_setting_reg[
                                        {1'b0, slot_select_field}];
                                    wiper_position_reg[1] <= stored_setting_reg[
                                        {1'b1, slot_select_field}];
                                end
                            default: ;
                        endcase
                        // Stored writes: busy guard, then program cycle
                        if (!write_pending_flag_out) begin
                            if ((opcode_field == `DPOT_OP_WR_SET && data_done) ||
                                (opcode_field == `DPOT_OP_WIPER_TO_SET &&
                                 !data_done) ||
                                (opcode_field == `DPOT_OP_GLB_TO_SET &&
                                 !data_done)) begin
                                write_pending_flag_out <= 1'b1;
                                nv_cnt <= 24'h000000;
                                if (opcode_field == `DPOT_OP_WR_SET)
                                    stored_setting_reg[sel_idx] <=
                                        data_byte;
                                else if (opcode_field == `DPOT_OP_WIPER_TO_SET)
                                    stored_setting_reg[sel_idx] <=
                                        wiper_position_reg[pot];
                                else begin
                                    stored_setting_reg[{1'b0,
                                        slot_select_field}] <=
                                        wiper_position_reg[0];
                                    stored_setting_reg[{1'b1,
                                        slot_select_field}] <=
                                        wiper_position_reg[1];
                                end
                            end
                        end
                        so_oe_out <= 1'b0;
                    end else if (sck_rise) begin
                        shift <= next_shift;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            data_byte <= next_shift;
                            data_done <= 1'b1;
                        end
                    end else if (sck_fall && !data_done) begin
                        // Reply driven after falling edge, MSB first
                        if (opcode_field == `DPOT_OP_RD_WIPER ||
                            opcode_field == `DPOT_OP_RD_SET ||
                            opcode_field == `DPOT_OP_STATUS) begin
                            so_oe_out <= 1'b1;
                            so_out <= tx[7];
                            tx <= {tx[6:0], 1'b0};
                        end
                    end
                end
                ST_STEP: begin
                    if (cs_rise) begin
                        state <= ST_ADDR;
                    end else if (sck_rise) begin
                        // Saturate at the array ends
                        if (si_sync[1]) begin
                            if (wiper_position_reg[pot] != 8'hff)
                                wiper_position_reg[pot] <=
                                    wiper_position_reg[pot] + 8'h01;
                        end else begin
                            if (wiper_position_reg[pot] != 8'h00)
                                wiper_position_reg[pot] <=
                                    wiper_position_reg[pot] - 8'h01;
                        end
                    end
                end
                ST_IGNORE: begin
                    so_oe_out <= 1'b0;
                    if (cs_rise)
                        state <= ST_ADDR;
                end
                default: state <= ST_ADDR;
            endcase
            if (cs_sync[1] && state != ST_DATA)
                so_oe_out <= 1'b0;
        end
    end

    // ************************************************************
    // Wiper response
    // ************************************************************
    // Analog side picks up both wipers once a mismatch has lasted the full allowed
    // delay on one shared count, so a later change can land sooner; registering the decoded taps keeps the tap switches glitch-free
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            settle_cnt <= 16'h0000;
            wiper0_out <= 8'h00;
            wiper1_out <= 8'h00;
            taps0_out <= {256{1'b0}};
            taps1_out <= {256{1'b0}};
        end else if (clk_en_in) begin
            if (wiper0_out != wiper_position_reg[0] ||
                wiper1_out != wiper_position_reg[1]) begin
                if (settle_cnt >= WIPER_DELAY_CYC[15:0] - 16'h0001) begin
                    settle_cnt <= 16'h0000;
                    wiper0_out <= wiper_position_reg[0];
                    wiper1_out <= wiper_position_reg[1];
                end else begin
                    settle_cnt <= settle_cnt + 16'h0001;
                end
            end else begin
                settle_cnt <= 16'h0000;
            end
            taps0_out <= dec0;
            taps1_out <= dec1;
        end
    end

    // Tap decoders per pot
    dpot_tap_decode u_dec0 (
        .position_in(wiper0_out),
        .taps_out(dec0)
    );
    dpot_tap_decode u_dec1 (
        .position_in(wiper1_out),
        .taps_out(dec1)
    );
endmodule // dpot_cmd_unit

// ===== verif/dpot_host_model.sv
// Host serial master model that frames commands for the pot unit
`timescale 1ns/10ps
module dpot_host_model (
    input wire logic clk_in, // Bench clock, changes land on falling edge
    input wire logic so_in,  // Serial reply from the device
    output logic sck_out,    // Serial clock, still between frames
    output logic cs_n_out,   // Chip select, active low
    output logic si_out      // Serial data to the device
);
    // ************************************************************
    // Frame engine
    // ************************************************************
    // Lines idle with select high and the clock parked low
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // Shifts nb bits MSB first at 320 ns per bit; the last 8 samples
    // of the reply land in rx, taken just before each rising edge
    task automatic frame(input logic [31:0] bits, input int nb,
                         output logic [7:0] rx);
        rx = 8'h00;
        @(negedge clk_in);
        cs_n_out = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int i = 0; i < nb; i++) begin
            sck_out = 1'b0;
            si_out = bits[31 - i];
            repeat (4) @(negedge clk_in);
            rx = {rx[6:0], so_in};
            sck_out = 1'b1;
            repeat (4) @(negedge clk_in);
        end
        sck_out = 1'b0;
        repeat (4) @(negedge clk_in);
        // Select rises straight after the last byte, so copies end here
        cs_n_out = 1'b1;
        // Released data line must not look like a held value
        si_out = ~si_out;
        repeat (8) @(negedge clk_in);
    endtask
endmodule // dpot_host_model

// ===== verif/dpot_cmd_monitor.sv
// Concurrent port checks for the pot command unit
`timescale 1ns/10ps
module dpot_cmd_monitor #(
    parameter int NV_WRITE_CYC = 125000 // Save duration in clocks
) (
    input wire clk_in,                 // System clock
    input wire reset_n_in,             // Async reset, active low
    input wire sck_in,                 // Serial clock pin
    input wire cs_n_in,                // Chip select pin
    input wire so_out,                 // Serial data out
    input wire so_oe_out,              // Serial out enable
    input wire write_pending_flag_out, // Save in progress
    input wire [7:0] wiper0_out,       // Wiper 0 position
    input wire [7:0] wiper1_out,       // Wiper 1 position
    input wire [255:0] taps0_out,      // Taps pot 0
    input wire [255:0] taps1_out       // Taps pot 1
);
    logic [31:0] pend_cnt;

    // Counts pending cycles so the save length can be judged at its end
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend_cnt <= 32'h0;
        end else begin
            pend_cnt <= write_pending_flag_out ? pend_cnt + 32'h1 : 32'h0;
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_cs_idle;
        cs_n_in [*6];
    endsequence
    sequence s_w1_calm;
        $stable(wiper1_out) [*3];
    endsequence

    a_taps0_follow: assert property (
        $changed(wiper0_out) |=> taps0_out == (256'h1 << $past(wiper0_out)))
        else $error("taps of pot 0 do not match its wiper");
    a_taps1_settled: assert property (
        s_w1_calm |-> taps1_out == (256'h1 << wiper1_out))
        else $error("taps of pot 1 not one-hot at its wiper");
    a_pend_length: assert property (
        $fell(write_pending_flag_out) |-> pend_cnt == NV_WRITE_CYC)
        else $error("save cycle length is wrong");
    a_pend_after_cs: assert property (
        $rose(write_pending_flag_out) |-> cs_n_in && $past(cs_n_in))
        else $error("save started while select was low");
    a_pend_holds: assert property (
        $rose(write_pending_flag_out) |=> write_pending_flag_out [*8])
        else $error("pending flag dropped too early");
    a_so_released: assert property (
        s_cs_idle |-> !so_oe_out)
        else $error("serial out driven while deselected");
    a_oe_in_frame: assert property (
        $rose(so_oe_out) |-> !cs_n_in && !sck_in)
        else $error("serial out enabled outside a low clock phase");
    a_so_after_fall: assert property (
        so_oe_out && $changed(so_out) |-> !sck_in && !$past(sck_in))
        else $error("serial out changed while clock high");
endmodule // dpot_cmd_monitor

bind dpot_cmd_unit dpot_cmd_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_mon (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck_in),
    .cs_n_in(cs_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .write_pending_flag_out(write_pending_flag_out),
    .wiper0_out(wiper0_out), .wiper1_out(wiper1_out),
    .taps0_out(taps0_out), .taps1_out(taps1_out));

// ===== verif/test_dual_pot_register_command_unit.sv
// Self-checking bench for the pot command unit
`timescale 1ns/10ps
`include "dpot_map.vh"
module test_dual_pot_register_command_unit;
    // Save shortened so one frame fits well inside it
    localparam int NV_CYC = 1000;
    localparam int WD_CYC = 4;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic [1:0] pins = 2'h2;
    wire logic sck, cs_n, si, so_out, so_oe_out, pend;
    wire logic [7:0] wiper0_out, wiper1_out;
    wire logic [255:0] taps0_out, taps1_out;
    // Undriven reply line shows the inverse so a stale bit cannot pass
    wire logic so_pin = so_oe_out ? so_out : ~so_out;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] rx;
    logic [7:0] bad [3] = '{8'h61, 8'h66, 8'h72};

    always #20 clk_in = ~clk_in;

    dpot_cmd_unit #(.NV_WRITE_CYC(NV_CYC), .WIPER_DELAY_CYC(WD_CYC)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
        .board_address_pins_in(pins), .so_out(so_out),
        .so_oe_out(so_oe_out), .write_pending_flag_out(pend),
        .wiper0_out(wiper0_out), .wiper1_out(wiper1_out),
        .taps0_out(taps0_out), .taps1_out(taps1_out));

    dpot_host_model host (.clk_in(clk_in), .so_in(so_pin), .sck_out(sck),
        .cs_n_out(cs_n), .si_out(si));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    // Address byte carries the fixed type code and this board's straps
    task automatic cmd(input logic [7:0] ins, input logic [7:0] dat,
                       input int nb);
        host.frame({`DPOT_TYPE_CODE, 2'b00, pins, ins, dat, 8'h00}, nb, rx);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic close_out;
        $display("mismatches %0d, checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Ceiling sits well above the roughly 7600 cycles the run needs
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        wait_cyc(16);
        reset_n_in = 1'b1;
        wait_cyc(8);
        check(wiper0_out, 8'h00);
        check(taps1_out, 256'h1);
        cmd(8'ha0, 8'ha5, 24);
        wait_cyc(16);
        check(wiper0_out, 8'ha5);
        check(taps0_out, 256'h1 << 8'ha5);
        cmd(8'h90, 8'h00, 24);
        check(rx, 8'ha5);
        check(so_oe_out, 1'b0);
        // Stored write, then a second one refused while the save runs
        cmd(8'hc9, 8'h3c, 24);
        check(pend, 1'b1);
        cmd(8'hcd, 8'h77, 24);
        cmd(8'h51, 8'h00, 24);
        check(rx, 8'h01);
        wait_cyc(NV_CYC);
        cmd(8'h51, 8'h00, 24);
        check(rx, 8'h00);
        cmd(8'hb9, 8'h00, 24);
        check(rx, 8'h3c);
        cmd(8'hbd, 8'h00, 24);
        check(rx, 8'h00);
        // Copies are two-byte frames
        cmd(8'hd9, 8'h00, 16);
        wait_cyc(16);
        check(wiper1_out, 8'h3c);
        cmd(8'he4, 8'h00, 16);
        check(pend, 1'b1);
        wait_cyc(NV_CYC);
        cmd(8'hb4, 8'h00, 24);
        check(rx, 8'ha5);
        cmd(8'h8c, 8'h00, 16);
        check(pend, 1'b1);
        wait_cyc(NV_CYC);
        cmd(8'hbc, 8'h00, 24);
        check(rx, 8'ha5);
        cmd(8'hbd, 8'h00, 24);
        check(rx, 8'h3c);
        cmd(8'ha0, 8'h00, 24);
        cmd(8'ha1, 8'hff, 24);
        cmd(8'h1c, 8'h00, 16);
        wait_cyc(16);
        check(wiper0_out, 8'ha5);
        check(wiper1_out, 8'h3c);
        // Step: up, up, down, up on pot 0; three downs on pot 1
        cmd(8'h20, 8'hd0, 20);
        cmd(8'h21, 8'h00, 19);
        wait_cyc(16);
        check(wiper0_out, 8'ha7);
        check(wiper1_out, 8'h39);
        // Wrong straps, nonzero spare bits and wrong type are all ignored
        foreach (bad[k]) host.frame({bad[k], 8'ha0, 8'h11, 8'h00}, 24, rx);
        wait_cyc(16);
        check(wiper0_out, 8'ha7);
        // A frame sent while the unit is frozen must leave no trace
        clk_en_in = 1'b0;
        cmd(8'ha0, 8'h11, 24);
        clk_en_in = 1'b1;
        wait_cyc(16);
        check(wiper0_out, 8'ha7);
        close_out();
    end
endmodule // test_dual_pot_register_command_unit
